// ---- csr_pkg.sv ----
package csr_pkg;

  // ---------------------------------------------------------------------
  // I/O addresses
  // ---------------------------------------------------------------------
  localparam int         ADDR_W       = 10;
  localparam logic [9:0] A_MODE_MONO  = 10'h3B8;
  localparam logic [9:0] A_MODE_COL   = 10'h3D8;
  localparam logic [9:0] A_CSEL       = 10'h3D9;
  localparam logic [9:0] A_PSET_MONO  = 10'h3B9;
  localparam logic [9:0] A_PSET_COL   = 10'h3DC;
  localparam logic [9:0] A_STAT1_MONO = 10'h3BA;
  localparam logic [9:0] A_STAT1_COL  = 10'h3DA;
  localparam logic [9:0] A_PCLR_MONO  = 10'h3BB;
  localparam logic [9:0] A_PCLR_COL   = 10'h3DB;
  localparam logic [9:0] A_PAGE_CFG   = 10'h3BF;
  localparam logic [9:0] A_STAT0_MISC = 10'h3C2;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int EC_EMU     = 2;
  localparam int EC_HWPAL   = 3;
  localparam int VRE_CLR    = 4;
  localparam int VRE_EN     = 5;
  localparam int MISC_IOSEL = 0;
  localparam int ST0_SW     = 4;
  localparam int ST0_FEAT0  = 5;
  localparam int ST0_FEAT1  = 6;
  localparam int ST0_IRQ    = 7;
  localparam int ST1_DE     = 0;
  localparam int ST1_PEN    = 1;
  localparam int ST1_PSW    = 2;
  localparam int ST1_VR     = 3;
  localparam int ST1_PAL0   = 4;
  localparam int ST1_PAL1   = 5;
  localparam int ST1_VS     = 7;
  localparam int MC_COL80   = 0;
  localparam int MC_GFX     = 1;
  localparam int MC_BW      = 2;
  localparam int MC_VIDEN   = 3;
  localparam int MC_HIRES   = 4;
  localparam int MC_BLINK   = 5;
  localparam int MC_PAGE    = 7;
  localparam int CS_ALT     = 4;
  localparam int CS_SET     = 5;

  // ---------------------------------------------------------------------
  // Masks, reset values and colours (IRGB)
  // ---------------------------------------------------------------------
  localparam logic [7:0] MC_MASK   = 8'hBF;
  localparam logic [7:0] CS_MASK   = 8'h3F;
  localparam logic [7:0] PAGE_MASK = 8'h03;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic       IOSEL_RST = 1'b0;
  localparam logic [3:0] COL_GREEN = 4'h2;
  localparam logic [3:0] COL_RED   = 4'h4;
  localparam logic [3:0] COL_BROWN = 4'h6;
  localparam logic [3:0] COL_CYAN  = 4'h3;
  localparam logic [3:0] COL_MAG   = 4'h5;
  localparam logic [3:0] COL_WHITE = 4'h7;
  localparam logic [3:0] COL_INTEN = 4'h8;

  typedef enum logic [1:0] {
    EM_NATIVE = 2'b00,
    EM_COLOUR = 2'b01,
    EM_MONO   = 2'b11
  } csr_emu_type;

  typedef struct packed {
    logic       disp_active;
    logic       hsync;
    logic       vretrace;
    logic       vsync_out;
    logic       sec_blue;
    logic       vsync_mon;
    logic [5:0] pal_video;
  } csr_video_type;

  typedef struct packed {
    logic col80;
    logic graphics;
    logic bw;
    logic video_en;
    logic hires;
    logic blink_en;
    logic page_upper;
  } csr_mode_type;

endpackage

// ---- csr_pixel_palette.sv ----
`timescale 1ns/1ns
module csr_pixel_palette (
  // Pixel and colour-select fields
  input  wire logic [1:0] pix_i,
  input  wire logic       colour_set_i,
  input  wire logic       alt_i,
  input  wire logic [3:0] bg_i,
  // Resulting IRGB colour
  output logic      [3:0] colour_o
);

  logic [3:0] base;

  // Code 00 always shows the background; the set bit picks the triple.
  always_comb begin
    base = bg_i;
    case (pix_i)
      2'b01:   base = colour_set_i ? csr_pkg::COL_CYAN  : csr_pkg::COL_GREEN;
      2'b10:   base = colour_set_i ? csr_pkg::COL_MAG   : csr_pkg::COL_RED;
      2'b11:   base = colour_set_i ? csr_pkg::COL_WHITE : csr_pkg::COL_BROWN;
      default: base = bg_i;
    endcase
  end

  assign colour_o = (alt_i && pix_i != 2'b00) ?
                    (base | csr_pkg::COL_INTEN) : base;

endmodule

// ---- csr_compat_status.sv ----
`timescale 1ns/1ns
// Overview of operation
// - Status0 bit4 returns switch-sense pin live.
// - Status0 bits5,6 return feature inputs 0,1.
// - Status0 bit7 mirrors the vertical interrupt output.
// - Interrupt enabled by bit5, held until bit4 clears.
// - Native/colour: status1 bit0 high during retrace.
// - Mono emulation: status1 bit0 shows horizontal sync.
// - Status1 bit1 shows light-pen latch, set by pulse.
// - Status1 bit2 shows light-pen switch live.
// - Bit3: native retrace, colour emulation vertical sync.
// - Mono emulation: bit3 shows secondary-blue video.
// - Native: bits4,5 are plane-selected palette outputs.
// - Emulation modes: status1 bits4,5 read one.
// - Bit7 monitor vsync in mono, else one.
// - Mode control gated by emulation, decoded by iosel.
// - Colour emulation: columns, monochrome, high resolution bits.
// - Both emulations: graphics and video-enable bits.
// - Both emulations: bit5 blink enable else intensity.
// - Mono graphics: bit7 selects upper memory page.
// - Colour select acts only with emulation, palette enable.
// - Colour select bits0-3 give border/background/foreground colour.
// - Colour select bit4 picks alternate intensified colours.
// - 320x200 pixel codes map to fixed colour sets.
// - Iosel maps ranges 3Bx/3Dx, resets zero.
module csr_compat_status (
  // Clock and reset
  input  wire logic                  clock_i,
  input  wire logic                  nrst_i,
  // Byte-wide I/O bus
  input  wire logic [9:0]            io_addr_i,
  input  wire logic                  io_wr_i,
  input  wire logic                  io_rd_i,
  input  wire logic [7:0]            io_wdata_i,
  output logic      [7:0]            io_rdata_o,
  output logic                       io_rdata_oe_o,
  // Board and connector pins
  input  wire logic                  switch_sense_i,
  input  wire logic                  feature_input_0_i,
  input  wire logic                  feature_input_1_i,
  input  wire logic                  pen_pulse_i,
  input  wire logic                  pen_switch_i,
  // Controller side signals
  input  wire csr_pkg::csr_video_type video_i,
  input  wire logic [1:0]            plane_enable_select_reg_i,
  input  wire logic [7:0]            emulation_control_reg_i,
  input  wire logic [7:0]            vertical_retrace_end_reg_i,
  input  wire logic                  vert_display_end_i,
  input  wire logic [1:0]            pixel_code_i,
  // Effective settings
  output logic                       vertical_irq_out_o,
  output logic                       io_select_o,
  output csr_pkg::csr_mode_type      mode_o,
  output logic                       hw_palette_o,
  output logic      [3:0]            csel_colour_o,
  output logic                       csel_alt_o,
  output logic      [3:0]            pixel_colour_o,
  output logic      [1:0]            page_cfg_o
);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  logic [7:0]            mode_reg_r;
  logic [7:0]            csel_r;
  logic [7:0]            page_cfg_r;
  logic                  iosel_r;
  logic                  irq_r;
  logic                  pen_latch_r;
  logic [7:0]            rdata_r;
  logic                  rdata_oe_r;
  csr_pkg::csr_mode_type mode_r;
  logic                  hwpal_r;
  logic [3:0]            csel_col_r;
  logic                  csel_alt_r;
  logic [3:0]            pix_col_r;

  // ---------------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------------
  logic                  emu_on;
  csr_pkg::csr_emu_type  emu_mode;
  logic [9:0]            a_mode;
  logic [9:0]            a_stat1;
  logic [9:0]            a_pset;
  logic [9:0]            a_pclr;
  logic                  wr_mode;
  logic                  wr_csel;
  logic                  wr_page;
  logic                  wr_misc;
  logic                  wr_pset;
  logic                  wr_pclr;
  logic                  rd_hit;
  logic [7:0]            stat0;
  logic [7:0]            stat1;
  logic [7:0]            rd_val;
  logic [1:0]            pal_pair;
  logic                  irq_en;
  logic                  irq_clr;
  logic                  irq_nxt;
  logic                  pen_nxt;
  logic [3:0]            pix_col;

  // Picks the palette pair routed to status bits 4 and 5.
  function automatic logic [1:0] pal_select(input logic [5:0] v,
                                            input logic [1:0] s);
    case (s)
      2'b01:   pal_select = {v[3], v[2]};
      2'b10:   pal_select = {v[5], v[4]};
      default: pal_select = {v[1], v[0]};
    endcase
  endfunction

  function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
    hit = (a == b);
  endfunction

  // The mode follows the emulation flag kept by software; hardware only
  // reads it, so a stale flag gives stale status formatting.
  assign emu_on   = emulation_control_reg_i[csr_pkg::EC_EMU];
  assign emu_mode = !emu_on ? csr_pkg::EM_NATIVE :
                    (iosel_r ? csr_pkg::EM_COLOUR : csr_pkg::EM_MONO);

  // Iosel picks the 3Dx or the 3Bx copy of each dual-mapped register.
  assign a_mode  = iosel_r ? csr_pkg::A_MODE_COL  : csr_pkg::A_MODE_MONO;
  assign a_stat1 = iosel_r ? csr_pkg::A_STAT1_COL : csr_pkg::A_STAT1_MONO;
  assign a_pset  = iosel_r ? csr_pkg::A_PSET_COL  : csr_pkg::A_PSET_MONO;
  assign a_pclr  = iosel_r ? csr_pkg::A_PCLR_COL  : csr_pkg::A_PCLR_MONO;

  assign wr_mode = io_wr_i && hit(io_addr_i, a_mode);
  assign wr_csel = io_wr_i && hit(io_addr_i, csr_pkg::A_CSEL);
  assign wr_page = io_wr_i && hit(io_addr_i, csr_pkg::A_PAGE_CFG);
  assign wr_misc = io_wr_i && hit(io_addr_i, csr_pkg::A_STAT0_MISC);
  assign wr_pset = io_wr_i && hit(io_addr_i, a_pset);
  assign wr_pclr = io_wr_i && hit(io_addr_i, a_pclr);

  // ---------------------------------------------------------------------
  // Status words
  // ---------------------------------------------------------------------
  assign pal_pair = pal_select(video_i.pal_video,
                               plane_enable_select_reg_i);

  always_comb begin
    stat0                      = 8'h00;
    stat0[csr_pkg::ST0_SW]     = switch_sense_i;
    stat0[csr_pkg::ST0_FEAT0]  = feature_input_0_i;
    stat0[csr_pkg::ST0_FEAT1]  = feature_input_1_i;
    stat0[csr_pkg::ST0_IRQ]    = irq_r;
  end

  always_comb begin
    stat1                   = 8'h00;
    stat1[csr_pkg::ST1_PEN] = pen_latch_r;
    stat1[csr_pkg::ST1_PSW] = pen_switch_i;
    case (emu_mode)
      csr_pkg::EM_MONO: begin
        stat1[csr_pkg::ST1_DE]   = video_i.hsync;
        stat1[csr_pkg::ST1_VR]   = video_i.sec_blue;
        stat1[csr_pkg::ST1_PAL0] = 1'b1;
        stat1[csr_pkg::ST1_PAL1] = 1'b1;
        stat1[csr_pkg::ST1_VS]   = video_i.vsync_mon;
      end
      csr_pkg::EM_COLOUR: begin
        stat1[csr_pkg::ST1_DE]   = !video_i.disp_active;
        stat1[csr_pkg::ST1_VR]   = video_i.vsync_out;
        stat1[csr_pkg::ST1_PAL0] = 1'b1;
        stat1[csr_pkg::ST1_PAL1] = 1'b1;
        stat1[csr_pkg::ST1_VS]   = 1'b1;
      end
      default: begin
        stat1[csr_pkg::ST1_DE]   = !video_i.disp_active;
        stat1[csr_pkg::ST1_VR]   = video_i.vretrace;
        stat1[csr_pkg::ST1_PAL0] = pal_pair[0];
        stat1[csr_pkg::ST1_PAL1] = pal_pair[1];
        stat1[csr_pkg::ST1_VS]   = 1'b1;
      end
    endcase
  end

  // Reads only copy a word out; nothing is cleared by a read.
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 8'h00;
    if (hit(io_addr_i, csr_pkg::A_STAT0_MISC)) begin
      rd_val = stat0;
    end else if (hit(io_addr_i, a_stat1)) begin
      rd_val = stat1;
    end else if (hit(io_addr_i, a_mode)) begin
      rd_val = mode_reg_r;
    end else if (hit(io_addr_i, csr_pkg::A_CSEL)) begin
      rd_val = csel_r;
    end else if (hit(io_addr_i, csr_pkg::A_PAGE_CFG)) begin
      rd_val = page_cfg_r;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------------
  assign irq_en  = vertical_retrace_end_reg_i[csr_pkg::VRE_EN];
  assign irq_clr = !vertical_retrace_end_reg_i[csr_pkg::VRE_CLR];
  // A new end-of-display event wins over a clear in the same cycle.
  assign irq_nxt = (vert_display_end_i && irq_en) ||
                   (irq_r && !irq_clr);
  assign pen_nxt = pen_pulse_i || wr_pset ||
                   (pen_latch_r && !wr_pclr);

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_reg_r <= csr_pkg::REG_RST;
      csel_r     <= csr_pkg::REG_RST;
      page_cfg_r <= csr_pkg::REG_RST;
      iosel_r    <= csr_pkg::IOSEL_RST;
    end else begin
      if (wr_mode) begin
        mode_reg_r <= io_wdata_i & csr_pkg::MC_MASK;
      end
      if (wr_csel) begin
        csel_r <= io_wdata_i & csr_pkg::CS_MASK;
      end
      if (wr_page) begin
        page_cfg_r <= io_wdata_i & csr_pkg::PAGE_MASK;
      end
      if (wr_misc) begin
        iosel_r <= io_wdata_i[csr_pkg::MISC_IOSEL];
      end
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_r       <= 1'b0;
      pen_latch_r <= 1'b0;
      rdata_r     <= 8'h00;
      rdata_oe_r  <= 1'b0;
    end else begin
      irq_r       <= irq_nxt;
      pen_latch_r <= pen_nxt;
      rdata_r     <= (io_rd_i && rd_hit) ? rd_val : 8'h00;
      rdata_oe_r  <= io_rd_i && rd_hit;
    end
  end

  // ---------------------------------------------------------------------
  // Effective mode and palette
  // ---------------------------------------------------------------------
  csr_pkg::csr_mode_type mode_nxt;
  logic                  csel_on;

  // Settings are gated rather than the writes, so software may preload
  // the registers before it turns emulation on.
  always_comb begin
    mode_nxt            = '0;
    if (emu_on) begin
      mode_nxt.graphics = mode_reg_r[csr_pkg::MC_GFX];
      mode_nxt.video_en = mode_reg_r[csr_pkg::MC_VIDEN];
      mode_nxt.blink_en = mode_reg_r[csr_pkg::MC_BLINK];
      if (iosel_r) begin
        mode_nxt.col80 = mode_reg_r[csr_pkg::MC_COL80];
        mode_nxt.bw    = mode_reg_r[csr_pkg::MC_BW];
        mode_nxt.hires = mode_reg_r[csr_pkg::MC_HIRES];
      end else begin
        mode_nxt.page_upper = mode_reg_r[csr_pkg::MC_PAGE] &&
                              mode_reg_r[csr_pkg::MC_GFX];
      end
    end
  end

  assign csel_on = emu_on &&
                   emulation_control_reg_i[csr_pkg::EC_HWPAL];

  csr_pixel_palette u_palette (
    .pix_i        (pixel_code_i),
    .colour_set_i (csel_r[csr_pkg::CS_SET]),
    .alt_i        (csel_r[csr_pkg::CS_ALT]),
    .bg_i         (csel_r[3:0]),
    .colour_o     (pix_col)
  );

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_r     <= '0;
      hwpal_r    <= 1'b0;
      csel_col_r <= 4'h0;
      csel_alt_r <= 1'b0;
      pix_col_r  <= 4'h0;
    end else begin
      mode_r     <= mode_nxt;
      hwpal_r    <= csel_on;
      csel_col_r <= csel_on ? csel_r[3:0] : 4'h0;
      csel_alt_r <= csel_on && csel_r[csr_pkg::CS_ALT];
      pix_col_r  <= csel_on ? pix_col : 4'h0;
    end
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign io_rdata_o         = rdata_r;
  assign io_rdata_oe_o      = rdata_oe_r;
  assign vertical_irq_out_o = irq_r;
  assign io_select_o        = iosel_r;
  assign mode_o             = mode_r;
  assign hw_palette_o       = hwpal_r;
  assign csel_colour_o      = csel_col_r;
  assign csel_alt_o         = csel_alt_r;
  assign pixel_colour_o     = pix_col_r;
  assign page_cfg_o         = page_cfg_r[1:0];

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  sequence rd_stat0_s;
    io_rd_i && hit(io_addr_i, csr_pkg::A_STAT0_MISC);
  endsequence

  sequence rd_stat1_s;
    io_rd_i && hit(io_addr_i, a_stat1);
  endsequence

  switch_bit_a: assert property (
    rd_stat0_s |=> io_rdata_oe_o && io_rdata_o[4] == $past(switch_sense_i))
    else $error("switch bit wrong");

  feature_bits_a: assert property (
    rd_stat0_s |=> io_rdata_o[6:5] ==
      $past({feature_input_1_i, feature_input_0_i}))
    else $error("feature bits wrong");

  irq_status_a: assert property (
    rd_stat0_s |=> io_rdata_o[7] == $past(vertical_irq_out_o))
    else $error("irq status bit wrong");

  irq_hold_a: assert property (
    vertical_irq_out_o && vertical_retrace_end_reg_i[4]
      |=> vertical_irq_out_o)
    else $error("irq dropped without clear");

  irq_set_a: assert property (
    vert_display_end_i && vertical_retrace_end_reg_i[5]
      |=> vertical_irq_out_o)
    else $error("irq not raised");

  pen_latch_a: assert property (
    pen_pulse_i |=> pen_latch_r)
    else $error("pen latch not set");

  pen_hold_a: assert property (
    pen_latch_r && !wr_pclr |=> pen_latch_r)
    else $error("pen latch dropped without clear");

  mono_hsync_a: assert property (
    (rd_stat1_s and (emu_mode == csr_pkg::EM_MONO))
      |=> io_rdata_o[0] == $past(video_i.hsync))
    else $error("mono bit0 wrong");

  emu_pal_a: assert property (
    (rd_stat1_s and emu_on) |=> io_rdata_o[5:4] == 2'b11)
    else $error("palette bits not high");

  mode_gate_a: assert property (
    !emu_on |=> mode_o == '0)
    else $error("mode active without emulation");

  csel_gate_a: assert property (
    !emulation_control_reg_i[3] |=> csel_colour_o == 4'h0 && !csel_alt_o)
    else $error("colour select active while disabled");

endmodule

// ---- csr_host_model.sv ----
`timescale 1ns/1ns
module csr_host_model (
  // Clock
  input  wire logic       clock_i,
  // Byte-wide I/O bus towards the block
  output logic      [9:0] io_addr_o,
  output logic            io_wr_o,
  output logic            io_rd_o,
  output logic      [7:0] io_wdata_o,
  input  wire logic [7:0] io_rdata_i,
  input  wire logic       io_rdata_oe_i
);
  initial begin
    io_addr_o  = 10'h000;
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_wdata_o = 8'h00;
  end

  // ---------------------------------------------------------------------
  // Bus cycles
  // ---------------------------------------------------------------------
  // Address and data are scrambled after each cycle, so a block that
  // samples them outside the strobe cycle sees the wrong value.
  task automatic release_bus();
    io_wr_o    = 1'b0;
    io_rd_o    = 1'b0;
    io_addr_o  = ~io_addr_o;
    io_wdata_o = ~io_wdata_o;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clock_i);
    #1;
    io_addr_o  = a;
    io_wdata_o = d;
    io_wr_o    = 1'b1;
    @(posedge clock_i);
    #1;
    release_bus();
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d,
                    output logic oe);
    @(posedge clock_i);
    #1;
    io_addr_o = a;
    io_rd_o   = 1'b1;
    @(posedge clock_i);
    #1;
    release_bus();
    d  = io_rdata_i;
    oe = io_rdata_oe_i;
  endtask
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ns
module testbench;
  logic                  clock_i = 1'b0;
  logic                  nrst_i  = 1'b0;
  logic [9:0]            io_addr;
  logic                  io_wr;
  logic                  io_rd;
  logic [7:0]            io_wdata;
  logic [7:0]            io_rdata;
  logic                  io_oe;
  logic                  sw = 1'b0, f0 = 1'b0, f1 = 1'b0;
  logic                  pen_pulse = 1'b0, pen_sw = 1'b0, vde = 1'b0;
  csr_pkg::csr_video_type video = '0;
  logic [1:0]            plane_sel = 2'b00, pix = 2'b00;
  logic [7:0]            emu = 8'h00, vre = 8'h00;
  logic                  irq, iosel, hwpal, alt;
  csr_pkg::csr_mode_type mode;
  logic [3:0]            csel_col, pix_col;
  logic [1:0]            page_cfg;
  logic [7:0]            rv;
  logic                  roe;
  logic [1:0]            pairs [4] = '{2'b00, 2'b01, 2'b10, 2'b00};
  logic [3:0]            cols [8] = '{4'h9, csr_pkg::COL_GREEN,
    csr_pkg::COL_RED, csr_pkg::COL_BROWN, 4'h9, csr_pkg::COL_CYAN,
    csr_pkg::COL_MAG, csr_pkg::COL_WHITE};
  int                    fails = 0, samples_checked = 0, cycles = 0;

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) \
  begin fails++; $display("BAD %0t got %h want %h", $time, got, exp); \
  end end

  always #5 clock_i = ~clock_i;

  csr_host_model u_csr_host_model (
    .clock_i      (clock_i),
    .io_addr_o    (io_addr),
    .io_wr_o      (io_wr),
    .io_rd_o      (io_rd),
    .io_wdata_o   (io_wdata),
    .io_rdata_i   (io_rdata),
    .io_rdata_oe_i(io_oe)
  );

  csr_compat_status u_csr_compat_status (
    .clock_i(clock_i), .nrst_i(nrst_i), .io_addr_i(io_addr),
    .io_wr_i(io_wr), .io_rd_i(io_rd), .io_wdata_i(io_wdata),
    .io_rdata_o(io_rdata), .io_rdata_oe_o(io_oe), .switch_sense_i(sw),
    .feature_input_0_i(f0), .feature_input_1_i(f1),
    .pen_pulse_i(pen_pulse), .pen_switch_i(pen_sw), .video_i(video),
    .plane_enable_select_reg_i(plane_sel), .emulation_control_reg_i(emu),
    .vertical_retrace_end_reg_i(vre), .vert_display_end_i(vde),
    .pixel_code_i(pix), .vertical_irq_out_o(irq), .io_select_o(iosel),
    .mode_o(mode), .hw_palette_o(hwpal), .csel_colour_o(csel_col),
    .csel_alt_o(alt), .pixel_colour_o(pix_col), .page_cfg_o(page_cfg)
  );

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    u_csr_host_model.wr(a, d);
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] m,
                        input logic [7:0] e);
    u_csr_host_model.rd(a, rv, roe);
    `CHK(roe, 1'b1)
    `CHK(rv & m, e)
  endtask

  task automatic pulse_vde();
    vde = 1'b1;
    step(1);
    vde = 1'b0;
    step(1);
  endtask

  task automatic tally_and_finish();
    if (fails == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // The whole sequence needs well under a thousand cycles.
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      tally_and_finish();
    end
  end

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    step(12);
    nrst_i = 1'b1;
    `CHK(iosel, 1'b0)
    sw = 1'b1;
    f1 = 1'b1;
    rd_chk(csr_pkg::A_STAT0_MISC, 8'hF0, 8'h50);
    {sw, f0, f1} = 3'b010;
    rd_chk(csr_pkg::A_STAT0_MISC, 8'hF0, 8'h20);
    vre = 8'h10;
    pulse_vde();
    `CHK(irq, 1'b0)
    vre = 8'h30;
    pulse_vde();
    step(20);
    `CHK(irq, 1'b1)
    rd_chk(csr_pkg::A_STAT0_MISC, 8'h80, 8'h80);
    vre = 8'h20;
    step(2);
    `CHK(irq, 1'b0)
    rd_chk(csr_pkg::A_STAT0_MISC, 8'h80, 8'h00);
    pen_sw = 1'b1;
    video.disp_active = 1'b1;
    video.vretrace = 1'b1;
    video.pal_video = 6'b100100;
    for (int i = 0; i < 4; i++) begin
      plane_sel = i[1:0];
      rd_chk(csr_pkg::A_STAT1_MONO, 8'hBF, 8'h8C | {pairs[i], 4'h0});
    end
    video.disp_active = 1'b0;
    rd_chk(csr_pkg::A_STAT1_MONO, 8'h01, 8'h01);
    pen_pulse = 1'b1;
    step(1);
    pen_pulse = 1'b0;
    rd_chk(csr_pkg::A_STAT1_MONO, 8'h02, 8'h02);
    rd_chk(csr_pkg::A_STAT1_MONO, 8'h02, 8'h02);
    wr(csr_pkg::A_PCLR_MONO, 8'h00);
    rd_chk(csr_pkg::A_STAT1_MONO, 8'h02, 8'h00);
    wr(csr_pkg::A_PSET_MONO, 8'h00);
    rd_chk(csr_pkg::A_STAT1_MONO, 8'h02, 8'h02);
    wr(csr_pkg::A_PCLR_MONO, 8'h00);
    wr(csr_pkg::A_STAT0_MISC, 8'h01);
    step(1);
    `CHK(iosel, 1'b1)
    emu = 8'h0C;
    rd_chk(csr_pkg::A_STAT1_COL, 8'hBF, 8'hB5);
    video.vsync_out = 1'b1;
    rd_chk(csr_pkg::A_STAT1_COL, 8'h08, 8'h08);
    wr(csr_pkg::A_MODE_COL, 8'hFF);
    step(2);
    `CHK(mode, 7'b1111110)
    rd_chk(csr_pkg::A_MODE_COL, 8'hFF, 8'hBF);
    u_csr_host_model.rd(csr_pkg::A_MODE_MONO, rv, roe);
    `CHK({roe, rv}, 9'h000)
    wr(csr_pkg::A_MODE_MONO, 8'h00);
    step(2);
    `CHK(mode, 7'b1111110)
    wr(csr_pkg::A_MODE_COL, 8'h15);
    step(2);
    `CHK(mode, 7'b1010100)
    `CHK(hwpal, 1'b1)
    for (int s = 0; s < 2; s++) begin
      wr(csr_pkg::A_CSEL, {2'b00, s[0], 5'h09});
      for (int c = 0; c < 4; c++) begin
        pix = c[1:0];
        step(2);
        `CHK(pix_col, cols[s * 4 + c])
      end
      `CHK(csel_col, 4'h9)
    end
    wr(csr_pkg::A_CSEL, 8'hF4);
    rd_chk(csr_pkg::A_CSEL, 8'hFF, 8'h34);
    pix = 2'b01;
    step(2);
    `CHK(alt, 1'b1)
    `CHK(pix_col, csr_pkg::COL_CYAN | csr_pkg::COL_INTEN)
    emu = 8'h04;
    step(2);
    `CHK({hwpal, csel_col}, 5'h00)
    wr(csr_pkg::A_STAT0_MISC, 8'h00);
    emu = 8'h0C;
    video = '0;
    video.hsync = 1'b1;
    video.disp_active = 1'b1;
    video.sec_blue = 1'b1;
    rd_chk(csr_pkg::A_STAT1_MONO, 8'hBF, 8'h3D);
    video.hsync = 1'b0;
    video.sec_blue = 1'b0;
    video.vsync_mon = 1'b1;
    rd_chk(csr_pkg::A_STAT1_MONO, 8'h89, 8'h80);
    wr(csr_pkg::A_MODE_MONO, 8'hBF);
    step(2);
    `CHK(mode, 7'b0101011)
    wr(csr_pkg::A_MODE_MONO, 8'h82);
    step(2);
    `CHK(mode, 7'b0100001)
    emu = 8'h00;
    step(2);
    `CHK(mode, 7'b0000000)
    wr(csr_pkg::A_PAGE_CFG, 8'hFF);
    step(1);
    `CHK(page_cfg, 2'b11)
    rd_chk(csr_pkg::A_PAGE_CFG, 8'hFF, 8'h03);
    tally_and_finish();
  end
endmodule
